//--- inc/seq_params.svh
// Constants for the start/stop sequencer: timing, scaling and reset values.
// Assumes a 125 MHz control clock; included by the package, whose macros the logic and bench use.
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
`define CLK_PERIOD_NS 8
`define HALT_MIN_MS 100
`define HALT_MIN_CYCLES ((`HALT_MIN_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STOP_TIME_DS_RST 16'h0064
`define FULL_SCALE 16'h7fff
`define DEMAND_ZERO 16'h0000
`define STOP_MODE_RAMP 1'b0
`define STOP_MODE_COAST 1'b1
`endif

//--- inc/seq_pkg.sv
// Types shared by the sequencer logic.
// Assumes the parameter header sits on the include path.
`include "seq_params.svh"
package seq_pkg;
	typedef enum logic [1:0] {
		SRC_LOCAL,
		SRC_REMOTE,
		SRC_UNUSED2,
		SRC_UNUSED3
	} ctrl_src_t;
	typedef enum logic [1:0] {
		WIRE_SINGLE,
		WIRE_TWO,
		WIRE_THREE,
		WIRE_RSVD
	} wire_mode_t;
endpackage

//--- logic/ramp_gen.sv
// Linear ramp generator: moves a value toward a target by a fixed step.
// Assumes target and step are stable from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module ramp_gen #(
	parameter int W = 16
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic force_zero_i,
	input wire logic [W-1:0] target_i,
	input wire logic [W-1:0] step_i,
	output logic [W-1:0] value_o
);
	logic [W:0] up_sum;
	logic [W-1:0] gap;
	always_comb begin
		up_sum = {1'b0, value_o} + {1'b0, step_i};
		gap = (value_o > target_i) ? value_o - target_i : target_i - value_o;
	end
	// Clamp to the target so a coarse step never overshoots.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || force_zero_i) begin
			value_o <= '0;
		end else if (gap <= step_i) begin
			value_o <= target_i;
		end else if (value_o < target_i) begin
			value_o <= up_sum[W-1:0];
		end else begin
			value_o <= value_o - step_i;
		end
	end
endmodule
`default_nettype wire

//--- logic/drive_start_stop_sequencer.sv
// Start/stop sequencer with ramped velocity_target for a motor drive.
// Assumes all operator pins are asynchronous and ramp settings come from
// local logic as step sizes (full scale over ramp ticks).
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Start and reference sources chosen separately.
// - Remote reference is sum of analogs.
// - Run ramps demand to reference, holds.
// - Inch ramps to inch setting while held.
// - Keypad run key latches until stop key.
// - Keypad inch only while key held.
// - Run or inch exclusive; stop between.
// - In-motion flag from start to stop end.
// - Fault-free flag unless tripped.
// - Reset to ramp stop, ten second stop (stop rate comes from stop_step_i; STOP_TIME_DS_RST is unused).
// - Ramp stop decelerates then trims to zero.
// - Power held until post-stop delay ends.
// - Zero decel or freeze uses stop rate.
// - Freewheel stop zeroes demand, disables power.
// - Quick stop overrides run and inch.
// - Forced freewheel disables, masks quick stop.
// - Trip coasts; hold off until reset.
// - Halt over 100 ms completes stop.
// - No start without power permit.
// - Two-wire: both commands asserted means stop.
// - Halt true latches momentary run commands.
// - Inch command never latched.
// - Permit false keeps power disabled.
module drive_start_stop_sequencer
	import seq_pkg::*;
#(
	parameter int W = 16,
	parameter int HALT_CYCLES = `HALT_MIN_CYCLES,
	parameter int DELAY_W = 24
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire seq_pkg::ctrl_src_t start_src_i,
	input wire seq_pkg::ctrl_src_t ref_src_i,
	input wire seq_pkg::wire_mode_t wire_mode_i,
	input wire logic run_stop_coast_i,
	input wire logic quick_stop_coast_i,
	input wire logic [W-1:0] analog_a_i,
	input wire logic [W-1:0] analog_b_i,
	input wire logic [W-1:0] keypad_speed_reference_i,
	input wire logic [W-1:0] inch_speed_setting_i,
	input wire logic [W-1:0] ramp_up_step_i,
	input wire logic [W-1:0] inch_ramp_up_step_i,
	input wire logic [W-1:0] ramp_down_step_i,
	input wire logic [W-1:0] stop_step_i,
	input wire logic [W-1:0] trim_i,
	input wire logic [DELAY_W-1:0] stop_delay_i,
	input wire logic key_run_i,
	input wire logic key_stop_i,
	input wire logic key_inch_i,
	input wire logic key_dir_i,
	input wire logic run_fwd_i,
	input wire logic run_rev_i,
	input wire logic reverse_i,
	input wire logic inch_command_i,
	input wire logic halt_n_i,
	input wire logic quick_stop_n_i,
	input wire logic coast_n_i,
	input wire logic ramp_freeze_i,
	input wire logic trip_i,
	input wire logic trip_reset_i,
	input wire logic permit_i,
	output logic [W-1:0] velocity_target_o,
	output logic [W-1:0] trim_out_o,
	output logic sequencer_direction_out_o,
	output logic stage_enable_o,
	output logic in_motion_o,
	output logic fault_free_flag_o,
	output logic stop_mode_o
);
	import seq_pkg::*;
	typedef enum {ST_IDLE, ST_RUN, ST_INCH, ST_DECEL, ST_TRIM, ST_DELAY,
		ST_TRIP} state_t;
	localparam int NS = 16;
	localparam int HALT_W = $clog2(HALT_CYCLES + 1);

	logic [NS-1:0] meta;
	logic [NS-1:0] sync;
	state_t state;
	logic [W-1:0] demand;
	logic [W-1:0] trim_val;
	logic [W-1:0] target;
	logic [W-1:0] step;
	logic [W:0] ref_sum;
	logic [W-1:0] remote_ref;
	logic [DELAY_W-1:0] delay_cnt;
	logic [HALT_W-1:0] halt_cnt;
	logic halt_req;
	logic run_latch;
	logic dir_latch;
	logic stop_mode;
	logic dir;
	logic want_run;
	logic want_inch;
	logic stop_now;
	logic coast_now;
	logic fast_stop;
	logic use_stop_rate;
	logic stopping;
	logic zero_demand;

	// Every operator pin passes two flops before any logic looks at it.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			meta <= '0;
			sync <= '0;
		end else begin
			meta <= {key_run_i, key_stop_i, key_inch_i, key_dir_i,
				run_fwd_i, run_rev_i, reverse_i, inch_command_i,
				halt_n_i, quick_stop_n_i, coast_n_i, ramp_freeze_i,
				trip_i, trip_reset_i, permit_i, 1'b0};
			sync <= meta;
		end
	end
	wire s_krun = sync[15];
	wire s_kstop = sync[14];
	wire s_kinch = sync[13];
	wire s_kdir = sync[12];
	wire s_fwd = sync[11];
	wire s_rev = sync[10];
	wire s_reverse = sync[9];
	wire s_inch = sync[8];
	wire s_halt_n = sync[7];
	wire s_qs_n = sync[6];
	wire s_coast_n = sync[5];
	wire s_freeze = sync[4];
	wire s_trip = sync[3];
	wire s_treset = sync[2];
	wire s_permit = sync[1];

	// Stop method is held here so reset lands on ramp stop.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			stop_mode <= `STOP_MODE_RAMP;
		end else if (state == ST_IDLE) begin
			stop_mode <= run_stop_coast_i;
		end
	end

	// A halt pulse must last the full qualify time; once seen, the request
	// stays until the sequencer is idle so an early release cannot abort.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			halt_cnt <= '0;
			halt_req <= 1'b0;
		end else begin
			if (s_halt_n) begin
				halt_cnt <= '0;
			end else if (halt_cnt != HALT_W'(HALT_CYCLES)) begin
				halt_cnt <= halt_cnt + 1'b1;
			end
			if (!s_halt_n && halt_cnt == HALT_W'(HALT_CYCLES)) begin
				halt_req <= 1'b1;
			end else if (state == ST_IDLE) begin
				halt_req <= 1'b0;
			end
		end
	end

	// Keypad run latch and remote three-wire latch of momentary run commands.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			run_latch <= 1'b0;
			dir_latch <= 1'b0;
		end else if (start_src_i == SRC_LOCAL) begin
			if (s_kstop) begin
				run_latch <= 1'b0;
			end else if (s_krun && s_permit) begin
				run_latch <= 1'b1;
			end
		end else if (!s_halt_n || wire_mode_i != WIRE_THREE) begin
			run_latch <= 1'b0;
		end else if ((s_fwd ^ s_rev) && s_permit) begin
			run_latch <= 1'b1;
			dir_latch <= s_rev;
		end
	end

	always_comb begin
		want_run = 1'b0;
		want_inch = 1'b0;
		dir = 1'b0;
		if (start_src_i == SRC_LOCAL) begin
			want_run = run_latch;
			want_inch = s_kinch;
		end else begin
			want_inch = s_inch;
			case (wire_mode_i)
				WIRE_SINGLE: want_run = s_fwd;
				WIRE_TWO: begin
					want_run = s_fwd ^ s_rev;
					dir = s_rev;
				end
				WIRE_THREE: begin
					want_run = run_latch;
					dir = dir_latch;
				end
				default: want_run = 1'b0;
			endcase
		end
		if (ref_src_i == SRC_LOCAL) begin
			dir = s_kdir;
		end else if (wire_mode_i == WIRE_SINGLE) begin
			dir = s_reverse;
		end
	end

	always_comb begin
		ref_sum = {1'b0, analog_a_i} + {1'b0, analog_b_i};
		remote_ref = ref_sum[W] ? `FULL_SCALE : ref_sum[W-1:0];
	end

	// Forced freewheel has priority and masks quick stop.
	assign coast_now = !s_coast_n || !s_permit;
	assign fast_stop = s_coast_n && !s_qs_n;
	assign stop_now = fast_stop || halt_req;

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
			delay_cnt <= '0;
		end else if (s_trip) begin
			state <= ST_TRIP;
		end else begin
			case (state)
				ST_IDLE: begin
					if (!coast_now && !stop_now) begin
						if (want_run) begin
							state <= ST_RUN;
						end else if (want_inch) begin
							state <= ST_INCH;
						end
					end
				end
				ST_RUN, ST_INCH: begin
					if (coast_now) begin
						state <= ST_IDLE;
					end else if (stop_now || (state == ST_RUN ? !want_run
						: !want_inch)) begin
						if ((fast_stop ? quick_stop_coast_i : stop_mode)
							== `STOP_MODE_COAST) begin
							state <= ST_IDLE;
						end else begin
							state <= ST_DECEL;
						end
					end
				end
				ST_DECEL: begin
					if (coast_now) begin
						state <= ST_IDLE;
					end else if (demand == `DEMAND_ZERO) begin
						state <= ST_TRIM;
					end
				end
				ST_TRIM: begin
					if (coast_now) begin
						state <= ST_IDLE;
					end else if (trim_val == `DEMAND_ZERO) begin
						state <= ST_DELAY;
						delay_cnt <= stop_delay_i;
					end
				end
				ST_DELAY: begin
					if (coast_now || delay_cnt == '0) begin
						state <= ST_IDLE;
					end else begin
						delay_cnt <= delay_cnt - 1'b1;
					end
				end
				ST_TRIP: begin
					if (!s_trip && s_treset) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign stopping = state == ST_DECEL || state == ST_TRIM
		|| state == ST_DELAY;
	assign use_stop_rate = ramp_down_step_i == '0 || s_freeze;
	assign zero_demand = state == ST_IDLE || state == ST_TRIP
		|| coast_now;

	always_comb begin
		target = `DEMAND_ZERO;
		step = use_stop_rate ? stop_step_i : ramp_down_step_i;
		if (state == ST_RUN) begin
			target = ref_src_i == SRC_LOCAL ? keypad_speed_reference_i
				: remote_ref;
			step = ramp_up_step_i;
		end else if (state == ST_INCH) begin
			target = inch_speed_setting_i;
			step = inch_ramp_up_step_i;
		end
	end

	ramp_gen #(.W(W)) u_demand (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.force_zero_i(zero_demand),
		.target_i(target),
		.step_i(step),
		.value_o(demand)
	);

	// The trim term decays at the stop rate once the demand is at zero.
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || zero_demand) begin
			trim_val <= '0;
		end else if (!stopping) begin
			trim_val <= trim_i;
		end else if (state != ST_DECEL) begin
			trim_val <= trim_val > stop_step_i ? trim_val - stop_step_i
				: `DEMAND_ZERO;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			velocity_target_o <= '0;
			trim_out_o <= '0;
			sequencer_direction_out_o <= 1'b0;
			stage_enable_o <= 1'b0;
			in_motion_o <= 1'b0;
			fault_free_flag_o <= 1'b1;
			stop_mode_o <= `STOP_MODE_RAMP;
		end else begin
			// Zeroed with the stage enable so a coast stop drops both together.
			velocity_target_o <= zero_demand ? `DEMAND_ZERO : demand;
			trim_out_o <= trim_val;
			if (state == ST_IDLE) begin
				sequencer_direction_out_o <= dir;
			end
			stage_enable_o <= !zero_demand;
			in_motion_o <= state != ST_IDLE && state != ST_TRIP;
			fault_free_flag_o <= state != ST_TRIP;
			stop_mode_o <= stop_mode;
		end
	end

	permit_gate_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!s_permit |=> !stage_enable_o)
		else $error("stage enabled without permit");
	coast_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!s_coast_n |=> !stage_enable_o)
		else $error("stage enabled during forced coast");
	trip_flag_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		s_trip |=> ##1 !fault_free_flag_o && !stage_enable_o)
		else $error("trip not reflected");
	motion_flag_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		stage_enable_o |-> in_motion_o)
		else $error("stage on while not in motion");
	start_permit_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		state == ST_IDLE && !s_permit |=> state != ST_RUN)
		else $error("started without permit");
	two_wire_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		state == ST_IDLE && start_src_i == SRC_REMOTE
		&& wire_mode_i == WIRE_TWO && s_fwd && s_rev |=> state != ST_RUN)
		else $error("two-wire both asserted started");
	run_inch_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		state == ST_RUN |=> state != ST_INCH)
		else $error("run went straight to inch");
	halt_stop_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		halt_req && state == ST_RUN |=> state != ST_RUN)
		else $error("halt did not stop run");
endmodule
`default_nettype wire

//--- verification/operator_stage_model.sv
// Far-side model: the operator's normally-closed halt push button.
// Assumes the sequencer samples the line through its own synchroniser.
`timescale 1ns/1ps
`default_nettype none
module operator_stage_model #(
	parameter int HOLD = 22
) (
	input wire logic mclk_i,
	output logic halt_n_o
);
	initial halt_n_o = 1'b1;
	// The press outlasts the qualify time so it is a real stop request.
	task automatic request_halt();
		@(posedge mclk_i);
		#1 halt_n_o = 1'b0;
		repeat (HOLD) @(posedge mclk_i);
		#1 halt_n_o = 1'b1;
	endtask
endmodule
`default_nettype wire

//--- verification/drive_start_stop_sequencer_tb.sv
// Self-checking bench for the start/stop sequencer.
// Assumes the design's package and parameter header are compiled first.
`timescale 1ns/1ps
`default_nettype none
module drive_start_stop_sequencer_tb;
	import seq_pkg::*;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1;
	ctrl_src_t start_src = SRC_REMOTE, ref_src = SRC_REMOTE;
	wire_mode_t wire_mode = WIRE_SINGLE;
	logic coast = 1'b0, key_run = 1'b0, key_stop = 1'b0, run_fwd = 1'b0;
	logic run_rev = 1'b0, trip = 1'b0, trip_rst = 1'b0, permit = 1'b1;
	logic qs_coast = 1'b0, key_inch = 1'b0, key_dir = 1'b0, reverse = 1'b0;
	logic inch = 1'b0, qs_n = 1'b1, coast_n = 1'b1, freeze = 1'b0;
	logic [15:0] inch_set = 16'h0300, up_step = 16'h0100;
	logic [15:0] down_step = 16'h0200, stop_step = 16'h0100;
	logic [15:0] trim = 16'h0000;
	logic halt_n;
	logic [15:0] vel, a, b, trim_o;
	logic en, moving, ok, smode, dir_o;
	int err_count = 0, n_compared = 0;
	always #4 mclk_i = ~mclk_i;
	operator_stage_model #(.HOLD(22)) partner (.mclk_i(mclk_i),
		.halt_n_o(halt_n));
	drive_start_stop_sequencer #(.HALT_CYCLES(20)) dut (.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i), .start_src_i(start_src), .ref_src_i(ref_src),
		.wire_mode_i(wire_mode), .run_stop_coast_i(coast),
		.quick_stop_coast_i(qs_coast), .analog_a_i(16'h0800),
		.analog_b_i(16'h0800), .keypad_speed_reference_i(16'h0600),
		.inch_speed_setting_i(inch_set), .ramp_up_step_i(up_step),
		.inch_ramp_up_step_i(16'h0080), .ramp_down_step_i(down_step),
		.stop_step_i(stop_step), .trim_i(trim), .stop_delay_i(24'h000010),
		.key_run_i(key_run), .key_stop_i(key_stop), .key_inch_i(key_inch),
		.key_dir_i(key_dir), .run_fwd_i(run_fwd), .run_rev_i(run_rev),
		.reverse_i(reverse), .inch_command_i(inch), .halt_n_i(halt_n),
		.quick_stop_n_i(qs_n), .coast_n_i(coast_n), .ramp_freeze_i(freeze),
		.trip_i(trip), .trip_reset_i(trip_rst), .permit_i(permit),
		.velocity_target_o(vel), .trim_out_o(trim_o),
		.sequencer_direction_out_o(dir_o),
		.stage_enable_o(en), .in_motion_o(moving), .fault_free_flag_o(ok),
		.stop_mode_o(smode));
	task automatic tick(int n = 1);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wait_en(logic lvl);
		int i;
		i = 0;
		while (en !== lvl && i < 100) begin
			tick();
			i++;
		end
		check("stage_enable", en, lvl);
	endtask
	task automatic t_remote_run();
		reverse = 1'b1;
		trim = 16'h0200;
		tick(4);
		run_fwd = 1'b1;
		wait_en(1'b1);
		check("in_motion", moving, 1'b1);
		check("direction", dir_o, 1'b1);
		a = vel;
		tick();
		b = vel;
		check("ramp_step", b - a, 16'h0100);
		tick(30);
		check("demand_held", vel, 16'h1000);
		check("trim_run", trim_o, 16'h0200);
		run_fwd = 1'b0;
		for (int i = 0; i < 40 && vel !== 16'h0000; i++) tick();
		check("demand_zero", vel, 16'h0000);
		check("stage_kept", en, 1'b1);
		tick(4);
		check("trim_decay", trim_o, 16'h0000);
		check("stage_trim", en, 1'b1);
		wait_en(1'b0);
		tick(2);
		check("in_motion_end", moving, 1'b0);
		reverse = 1'b0;
		trim = 16'h0000;
	endtask
	task automatic t_freeze();
		run_fwd = 1'b1;
		wait_en(1'b1);
		tick(30);
		freeze = 1'b1;
		tick(4);
		run_fwd = 1'b0;
		tick(6);
		a = vel;
		tick();
		check("freeze_step", a - vel, 16'h0100);
		wait_en(1'b0);
		freeze = 1'b0;
		tick(4);
	endtask
	task automatic t_coast();
		coast = 1'b1;
		tick(2);
		run_fwd = 1'b1;
		wait_en(1'b1);
		tick(20);
		run_fwd = 1'b0;
		for (int i = 0; i < 8 && en !== 1'b0; i++) tick();
		check("coast_stage", en, 1'b0);
		check("coast_demand", vel, 16'h0000);
		coast = 1'b0;
		tick(4);
	endtask
	task automatic t_forced();
		qs_coast = 1'b1;
		run_fwd = 1'b1;
		wait_en(1'b1);
		qs_n = 1'b0;
		for (int i = 0; i < 8 && en !== 1'b0; i++) tick();
		check("quick_stage", en, 1'b0);
		check("quick_demand", vel, 16'h0000);
		tick(6);
		check("quick_held", en, 1'b0);
		qs_n = 1'b1;
		wait_en(1'b1);
		coast_n = 1'b0;
		qs_n = 1'b0;
		for (int i = 0; i < 8 && en !== 1'b0; i++) tick();
		check("coast_pin", en, 1'b0);
		run_fwd = 1'b0;
		coast_n = 1'b1;
		qs_n = 1'b1;
		qs_coast = 1'b0;
		tick(6);
		check("coast_idle", en, 1'b0);
	endtask
	task automatic t_inch();
		inch = 1'b1;
		wait_en(1'b1);
		tick(12);
		check("inch_speed", vel, 16'h0300);
		inch = 1'b0;
		wait_en(1'b0);
		tick(2);
	endtask
	task automatic t_refusals();
		permit = 1'b0;
		run_fwd = 1'b1;
		tick(12);
		check("no_permit", en, 1'b0);
		run_fwd = 1'b0;
		tick(2);
		permit = 1'b1;
		wire_mode = WIRE_TWO;
		run_fwd = 1'b1;
		run_rev = 1'b1;
		tick(12);
		check("both_cmds", en, 1'b0);
		run_fwd = 1'b0;
		run_rev = 1'b0;
		tick(4);
	endtask
	task automatic t_trip();
		wire_mode = WIRE_SINGLE;
		run_fwd = 1'b1;
		wait_en(1'b1);
		trip = 1'b1;
		tick(6);
		check("trip_stage", en, 1'b0);
		check("trip_flag", ok, 1'b0);
		run_fwd = 1'b0;
		trip = 1'b0;
		tick(6);
		check("trip_held", ok, 1'b0);
		trip_rst = 1'b1;
		tick(4);
		trip_rst = 1'b0;
		tick(6);
		check("trip_cleared", ok, 1'b1);
	endtask
	task automatic t_latch_halt();
		wire_mode = WIRE_THREE;
		run_fwd = 1'b1;
		tick(4);
		run_fwd = 1'b0;
		wait_en(1'b1);
		tick(10);
		check("latched_run", en, 1'b1);
		partner.request_halt();
		wait_en(1'b0);
		tick(10);
		check("halt_done", en, 1'b0);
		wire_mode = WIRE_SINGLE;
	endtask
	task automatic t_keypad();
		start_src = SRC_LOCAL;
		ref_src = SRC_LOCAL;
		key_dir = 1'b1;
		tick(4);
		key_run = 1'b1;
		tick(4);
		key_run = 1'b0;
		wait_en(1'b1);
		check("key_dir", dir_o, 1'b1);
		tick(20);
		check("key_latched", en, 1'b1);
		check("local_ref", vel, 16'h0600);
		key_stop = 1'b1;
		tick(4);
		key_stop = 1'b0;
		wait_en(1'b0);
		key_dir = 1'b0;
		tick(2);
		key_inch = 1'b1;
		wait_en(1'b1);
		tick(12);
		check("key_inch_speed", vel, 16'h0300);
		key_inch = 1'b0;
		wait_en(1'b0);
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		test_done();
	end
	initial begin
		tick(4);
		sys_rst_i = 1'b0;
		tick();
		check("reset_demand", vel, 16'h0000);
		check("reset_ok", ok, 1'b1);
		check("reset_mode", smode, `STOP_MODE_RAMP);
		t_remote_run();
		t_freeze();
		t_coast();
		t_forced();
		t_inch();
		t_refusals();
		t_trip();
		t_latch_halt();
		t_keypad();
		test_done();
	end
endmodule
`default_nettype wire
